// [hdl/reset_clock_supervisor.sv]
// Reset sequencer, power-state control, watchdog and clock selection.
// Assumes APB master on sys_clk and all status inputs synchronous to it.
`timescale 1ns/1ps
module reset_clock_supervisor
   import rcs_pkg::*;
#(
   parameter int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYCLES_DEF,
   parameter int OST_CYCLES  = OST_CYCLES_DEF,
   parameter int WDT_TICKS   = WDT_TICKS_DEF
)(
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic [7:0]   paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire boot_cfg_type bootCfg,
   input  wire logic         porEvent,
   input  wire logic         brownoutDet,
   input  wire logic         extResetN,
   input  wire logic         wdtOscTick,
   input  wire logic         primActivity,
   input  wire logic         wakeIrq,
   output logic              coreResetN,
   output clk_ctrl_type      clkCtrl,
   output logic [1:0]        borTripSel,
   output logic              irq
);
   localparam logic [TMR_W-1:0] POWERUP_DELAY_TIMER_LOAD = TMR_W'(POWERUP_DELAY_TIMER_CYCLES);
   localparam logic [TMR_W-1:0] OST_LOAD  = TMR_W'(OST_CYCLES);
   localparam logic [TMR_W-1:0] WDT_LAST  = TMR_W'(WDT_TICKS - 1);

   pwr_state_type        state_r, state_nxt;
   clk_src_type          curSrc_r;
   logic [1:0]           postSel_r, pllMul_r;
   logic                 cfmEn_r, failFlag_r, swWdtEn_r, bootDone_r, powerupPend_r;
   logic [TMR_W-1:0]     wdtCnt_r;
   logic                 wdtBite_r;
   logic [POST_W-1:0]    postCnt_r;
   logic                 sysTick_r, coreResetN_r;
   logic [IRQ_W-1:0]     irqStat_r, irqMask_r;
   logic [CAUSE_W-1:0]   cause_r;
   logic [31:0]          prdata_r;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   wire selClk   = (paddr == CLK_CTRL_OFS);
   wire selPwr   = (paddr == PWR_CTRL_OFS);
   wire selStat  = (paddr == IRQ_STAT_OFS);
   wire selMask  = (paddr == IRQ_MASK_OFS);
   wire selCause = (paddr == RST_CAUSE_OFS);
   wire mapped   = selClk || selPwr || selStat || selMask || selCause;
   wire access   = psel && penable;
   wire wrEn     = access && pwrite && mapped;
   wire wrClk    = wrEn && selClk;
   wire wrPwr    = wrEn && selPwr;

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = prdata_r;

   wire clk_src_type newSrc = clk_src_type'(pwdata[CC_NEWSRC_LSB +: 2]);
   wire swReq    = wrClk && pwdata[CC_SWITCH_BIT] && (state_r == ST_RUN)
                   && (newSrc != curSrc_r);
   wire idleReq  = wrPwr && pwdata[PC_IDLE_BIT];
   wire sleepReq = wrPwr && pwdata[PC_SLEEP_BIT];
   wire wdtClr   = wrPwr && pwdata[PC_WDT_CLR_BIT];

   wire [31:0] clkCtrlRd = {16'h0000, failFlag_r, 1'b0, curSrc_r, 3'b000, cfmEn_r,
                            pllMul_r, postSel_r, 4'h0};
   wire [31:0] pwrCtrlRd = {31'h0000_0000, swWdtEn_r};
   wire [31:0] readMux   = selClk   ? clkCtrlRd :
                           selPwr   ? pwrCtrlRd :
                           selStat  ? {28'h000_0000, irqStat_r} :
                           selMask  ? {28'h000_0000, irqMask_r} :
                           selCause ? {28'h000_0000, cause_r} : 32'h0000_0000;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= readMux;
      end
   end

   // ----------------------------------------------------------------------
   // Reset sources and holding timers
   // ----------------------------------------------------------------------
   wire wdtEnable  = bootCfg.wdtOn || swWdtEn_r;                     // [RL1]
   wire wdtReset   = wdtBite_r && (state_r == ST_RUN);
   wire srcAsserted = porEvent || brownoutDet || !extResetN || wdtReset; // [RL5]
   wire timersGo   = (state_r == ST_RESET) && !srcAsserted;
   wire pwrtStart  = timersGo && powerupPend_r && bootCfg.pwrtEn;    // [RL4]
   // The boot source loads on the edge that starts the timers, so look ahead to it.
   wire ostStart   = timersGo && needsOst(bootDone_r ? curSrc_r : bootCfg.oscSel); // [RL3]
   logic pwrtBusy, ostBusy;

   hold_timer u_powerup_delay_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (pwrtStart),
      .load    (POWERUP_DELAY_TIMER_LOAD),
      .busy    (pwrtBusy)
   );

   hold_timer u_ost (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (ostStart),
      .load    (OST_LOAD),
      .busy    (ostBusy)
   );

   assign borTripSel = bootCfg.borLevel;                             // [RL5]

   // ----------------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------------
   wire wakeEvt = ((state_r == ST_SLEEP) || (state_r == ST_IDLE))
                  && !srcAsserted && (wakeIrq || wdtBite_r);         // [RL6]

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: begin
            if (!srcAsserted) state_nxt = ST_HOLD;
         end
         ST_HOLD: begin
            if (srcAsserted) state_nxt = ST_RESET;
            else if (!pwrtBusy && !ostBusy) state_nxt = ST_RUN;      // [RL12]
         end
         ST_RUN: begin
            if (srcAsserted) state_nxt = ST_RESET;
            else if (sleepReq) state_nxt = ST_SLEEP;
            else if (idleReq) state_nxt = ST_IDLE;
         end
         ST_IDLE, ST_SLEEP: begin
            if (srcAsserted) state_nxt = ST_RESET;
            else if (wakeEvt) state_nxt = ST_RUN;                    // [RL6]
         end
         default: state_nxt = ST_RESET;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_r       <= ST_RESET;
         coreResetN_r  <= 1'b0;
         powerupPend_r <= 1'b1;
      end else begin
         state_r       <= state_nxt;
         coreResetN_r  <= (state_nxt != ST_RESET) && (state_nxt != ST_HOLD); // [RL12]
         if (porEvent) powerupPend_r <= 1'b1;
         else if (timersGo) powerupPend_r <= 1'b0;                   // [RL4]
      end
   end

   assign coreResetN = coreResetN_r;

   // ----------------------------------------------------------------------
   // Watchdog on its own oscillator ticks
   // ----------------------------------------------------------------------
   // Counting only on wdtOscTick keeps the watchdog alive if the system source dies.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wdtCnt_r  <= '0;
         wdtBite_r <= 1'b0;
      end else begin
         wdtBite_r <= 1'b0;
         if (!wdtEnable || wdtClr || state_r == ST_RESET) begin
            wdtCnt_r <= '0;
         end else if (wdtOscTick) begin                              // [RL2]
            if (wdtCnt_r == WDT_LAST) begin
               wdtCnt_r  <= '0;
               wdtBite_r <= 1'b1;
            end else begin
               wdtCnt_r <= wdtCnt_r + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Clock selection, fail monitor, PLL and postscaler
   // ----------------------------------------------------------------------
   logic cfmFail;
   wire  loadBoot = porEvent || brownoutDet || !bootDone_r;

   clk_fail_monitor u_cfm (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .enable   (cfmEn_r && curSrc_r == SRC_PRIMARY && state_r != ST_SLEEP),
      .activity (primActivity),
      .failed   (cfmFail)
   );

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         curSrc_r   <= SRC_FRC;
         bootDone_r <= 1'b0;
         failFlag_r <= 1'b0;
      end else begin
         bootDone_r <= 1'b1;
         if (loadBoot) begin
            curSrc_r   <= bootCfg.oscSel;                            // [RL8]
            failFlag_r <= 1'b0;
         end else if (cfmFail) begin
            curSrc_r   <= SRC_FRC;                                   // [RL10]
            failFlag_r <= 1'b1;
         end else if (swReq) begin
            curSrc_r   <= newSrc;                                    // [RL9]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         postSel_r <= FIELD2_RST;
         pllMul_r  <= FIELD2_RST;
         cfmEn_r   <= 1'b0;
         swWdtEn_r <= 1'b0;
      end else begin
         if (wrClk) begin
            postSel_r <= pwdata[CC_POST_LSB +: 2];                   // [RL11]
            pllMul_r  <= pwdata[CC_PLL_LSB +: 2];                    // [RL11]
            cfmEn_r   <= pwdata[CC_CFM_EN_BIT];
         end
         if (wrPwr) swWdtEn_r <= pwdata[PC_WDT_EN_BIT];              // [RL1]
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         postCnt_r <= '0;
         sysTick_r <= 1'b0;
      end else if (postCnt_r >= postLimit(postSel_r)) begin
         postCnt_r <= '0;
         sysTick_r <= 1'b1;                                          // [RL11]
      end else begin
         postCnt_r <= postCnt_r + 1'b1;
         sysTick_r <= 1'b0;
      end
   end

   assign clkCtrl.oscEn       = (state_r != ST_SLEEP);               // [RL7]
   assign clkCtrl.coreClkEn   = (state_r == ST_RUN);                 // [RL7]
   assign clkCtrl.periphClkEn = (state_r == ST_RUN) || (state_r == ST_IDLE);
   assign clkCtrl.src         = curSrc_r;
   assign clkCtrl.pllMul      = pllMul_r;
   assign clkCtrl.sysTick     = sysTick_r && (state_r != ST_SLEEP);

   // ----------------------------------------------------------------------
   // Interrupt status, mask and reset cause
   // ----------------------------------------------------------------------
   wire [IRQ_W-1:0]   irqSet   = {swReq, wakeEvt, cfmFail, wdtBite_r};
   wire [IRQ_W-1:0]   irqClr   = (wrEn && selStat) ? pwdata[IRQ_W-1:0] : IRQ_RST;
   wire [CAUSE_W-1:0] causeSet = {wdtReset, !extResetN, brownoutDet, porEvent};
   wire [CAUSE_W-1:0] causeClr = (wrEn && selCause) ? pwdata[CAUSE_W-1:0] : CAUSE_RST;

   // Set wins over a write-one clear landing in the same cycle.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irqStat_r <= IRQ_RST;
         irqMask_r <= IRQ_RST;
         cause_r   <= CAUSE_RST;
      end else begin
         irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
         cause_r   <= (cause_r & ~causeClr) | causeSet;
         if (wrEn && selMask) irqMask_r <= pwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irqStat_r & irqMask_r);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence holdBusy;
      (state_r == ST_HOLD) && (pwrtBusy || ostBusy);
   endsequence

   a_release_after_timers: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL12]
      holdBusy |=> (state_r != ST_RUN) && !coreResetN) else $error("early release");
   a_ost_holds_core: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL3]
      ostStart |=> ostBusy ##1 !coreResetN) else $error("start-up delay skipped");
   a_powerup_delay_timer_powerup_only: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL4]
      $rose(pwrtBusy) |-> $past(powerupPend_r)) else $error("power-up delay off cause");
   a_brownout_resets: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL5]
      brownoutDet |=> (state_r == ST_RESET) ##1 !coreResetN) else $error("brown-out ignored");
   a_wdt_needs_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL1]
      wdtBite_r |-> $past(bootCfg.wdtOn || swWdtEn_r)) else $error("watchdog not enabled");
   a_wdt_own_ticks: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL2]
      (wdtCnt_r > $past(wdtCnt_r)) |-> $past(wdtOscTick)) else $error("watchdog miscounted");
   a_sleep_wakes: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL6]
      (state_r == ST_SLEEP && wakeIrq && !srcAsserted) |=> state_r == ST_RUN)
      else $error("no wake from sleep");
   a_power_states: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL7]
      (state_r == ST_IDLE) |-> clkCtrl.oscEn && !clkCtrl.coreClkEn && clkCtrl.periphClkEn)
      else $error("idle clocks wrong");
   a_sleep_powerdown: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL7]
      (state_r == ST_SLEEP) |-> !clkCtrl.oscEn && !clkCtrl.periphClkEn)
      else $error("sleep clocks running");
   a_boot_source: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL8]
      porEvent |=> curSrc_r == $past(bootCfg.oscSel)) else $error("boot source not loaded");
   a_switch_source: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL9]
      (swReq && !loadBoot && !cfmFail) |=> curSrc_r == $past(newSrc) && irqStat_r[IRQ_SWDONE])
      else $error("switch not done");
   a_fail_safe: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL10]
      (cfmFail && !loadBoot) |=> (curSrc_r == SRC_FRC) && failFlag_r) else $error("no fail-safe");
   a_postscale_gap: assert property (@(posedge sys_clk) disable iff (!nrst) // [RL11]
      (sysTick_r && postSel_r == 2'd1 && !wrClk) [*1] ##1 (postSel_r == 2'd1 && !wrClk) [*3]
      |=> sysTick_r) else $error("postscaler period");

endmodule

// [hdl/rcs_pkg.sv]
// Constants, types and register map of the reset and clock supervisor.
// Assumes one 100 MHz system clock and an APB register port with 32-bit data.
//
// Summary of operation
// RL1: Watchdog runs when the boot setting forces it or software enables it.
// RL2: Watchdog counts ticks of its own RC oscillator, not the system clock.
// RL3: Oscillator start-up timer holds reset while a crystal source settles.
// RL4: Power-up delay timer runs only after a power-up event, never otherwise.
// RL5: Reset sources: power-on, power-up delay, start-up timer, programmable brown-out.
// RL6: Sleep ends on external reset, watchdog wake-up or an enabled interrupt.
// RL7: Idle keeps clock sources running and stops the core; Sleep powers down.
// RL8: Power-on or brown-out reset loads the boot clock source; switching stays allowed.
// RL9: One clock control register switches sources and reports clock status.
// RL10: Loss of the primary clock is detected and the fast RC source takes over.
// RL11: PLL multiplier select and a programmable system clock postscaler are provided.
// RL12: Internal reset releases only when all active timers expired and no source asserts.
package rcs_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  CLK_CTRL_OFS  = 8'h00;
   localparam logic [7:0]  PWR_CTRL_OFS  = 8'h04;
   localparam logic [7:0]  IRQ_STAT_OFS  = 8'h08;
   localparam logic [7:0]  IRQ_MASK_OFS  = 8'h0C;
   localparam logic [7:0]  RST_CAUSE_OFS = 8'h10;

   localparam int CC_NEWSRC_LSB = 0;
   localparam int CC_SWITCH_BIT = 2;
   localparam int CC_POST_LSB   = 4;
   localparam int CC_PLL_LSB    = 6;
   localparam int CC_CFM_EN_BIT = 8;
   localparam int CC_CURSRC_LSB = 12;
   localparam int CC_FAIL_BIT   = 15;

   localparam int PC_WDT_EN_BIT  = 0;
   localparam int PC_IDLE_BIT    = 1;
   localparam int PC_SLEEP_BIT   = 2;
   localparam int PC_WDT_CLR_BIT = 3;

   localparam int IRQ_W       = 4;
   localparam int IRQ_WDT     = 0;
   localparam int IRQ_CFAIL   = 1;
   localparam int IRQ_WAKE    = 2;
   localparam int IRQ_SWDONE  = 3;

   localparam int CAUSE_W   = 4;
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_BOR = 1;
   localparam int CAUSE_EXT = 2;
   localparam int CAUSE_WDT = 3;

   localparam logic [IRQ_W-1:0]   IRQ_RST   = 4'h0;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 4'h0;
   localparam logic [1:0]         FIELD2_RST = 2'h0;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int TMR_W             = 16;
   localparam int POWERUP_DELAY_TIMER_CYCLES_DEF   = 1024;
   localparam int OST_CYCLES_DEF    = 1024;
   localparam int WDT_TICKS_DEF     = 512;
   localparam int CFM_LIMIT         = 64;
   localparam int POST_W            = 6;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_FRC       = 2'b00,
      SRC_LPRC      = 2'b01,
      SRC_PRIMARY   = 2'b10,
      SRC_SECONDARY = 2'b11
   } clk_src_type;

   typedef enum logic [2:0] {
      ST_RESET = 3'b000,
      ST_HOLD  = 3'b001,
      ST_RUN   = 3'b010,
      ST_IDLE  = 3'b011,
      ST_SLEEP = 3'b100
   } pwr_state_type;

   typedef struct packed {
      logic        wdtOn;
      logic        pwrtEn;
      logic [1:0]  borLevel;
      clk_src_type oscSel;
   } boot_cfg_type;

   typedef struct packed {
      logic        oscEn;
      logic        coreClkEn;
      logic        periphClkEn;
      clk_src_type src;
      logic [1:0]  pllMul;
      logic        sysTick;
   } clk_ctrl_type;

   // Crystal sources need the start-up delay before the core may run.
   function automatic logic needsOst(input clk_src_type src);
      return (src == SRC_PRIMARY) || (src == SRC_SECONDARY);
   endfunction

   // Postscaler divides by 1, 4, 16 or 64.
   function automatic logic [POST_W-1:0] postLimit(input logic [1:0] sel);
      case (sel)
         2'd0:    return 6'h00;
         2'd1:    return 6'h03;
         2'd2:    return 6'h0F;
         default: return 6'h3F;
      endcase
   endfunction

endpackage

// [hdl/hold_timer.sv]
// One-shot down counter that reports busy while a reset-holding delay runs.
// Assumes start is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
module hold_timer
   import rcs_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic             start,
   input  wire logic [TMR_W-1:0] load,
   output logic                  busy
);
   logic [TMR_W-1:0] cnt_r;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (start) begin
         cnt_r <= load;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign busy = (cnt_r != '0);

endmodule

// [hdl/clk_fail_monitor.sv]
// Watches activity pulses of the primary clock and flags its loss.
// Assumes activity is a pulse per primary clock edge, resampled onto sys_clk.
`timescale 1ns/1ps
module clk_fail_monitor
   import rcs_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic enable,
   input  wire logic activity,
   output logic      failed
);
   localparam logic [7:0] LAST = 8'(CFM_LIMIT - 1);
   logic [7:0] gap_r;

   // A silent gap one cycle short of the full limit raises one pulse; the count then rests at LAST.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gap_r <= '0;
      end else if (!enable || activity) begin
         gap_r <= '0;
      end else if (gap_r != LAST) begin
         gap_r <= gap_r + 1'b1;
      end
   end

   assign failed = enable && !activity && (gap_r == LAST - 8'h01); // [RL10]

endmodule

// [tb/core_model.sv]
// Far-side model: the primary crystal and the watchdog RC oscillator.
// Assumes it is clocked by sys_clk and driven by the bench's enable levels.
`timescale 1ns/1ps
module core_model
   import rcs_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire clk_ctrl_type clkCtrl,
   input  wire logic         primOn,
   input  wire logic         tickOn,
   output logic              primActivity,
   output logic              wdtOscTick
);
   logic [1:0] div_r;
   initial div_r = 2'h0;
   always @(posedge sys_clk) begin
      div_r <= div_r + 2'h1;
      // The crystal only toggles while powered; a dead crystal gives no edges.
      primActivity <= primOn && clkCtrl.oscEn && div_r[0];
      // The RC oscillator runs apart from the system clock selection.
      wdtOscTick <= tickOn && (div_r == 2'h3);
   end
endmodule

// [tb/tb_reset_clock_supervisor.sv]
// Self-checking bench of the reset and clock supervisor.
// Assumes the design package and modules are compiled before it.
`timescale 1ns/1ps
module tb_reset_clock_supervisor
   import rcs_pkg::*;
;
   logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
   logic pready, pslverr, porEvent = 0, brownoutDet = 0, extResetN = 1, wakeIrq = 0;
   logic primActivity, wdtOscTick, coreResetN, irq, primOn = 1, tickOn = 0, err;
   logic [1:0] borTripSel;
   clk_ctrl_type clkCtrl;
   boot_cfg_type bootCfg = '{1'b0, 1'b1, 2'b10, SRC_PRIMARY};
   int miscompares = 0, checks = 0, n;
   always #5 sys_clk = ~sys_clk;
   reset_clock_supervisor #(.POWERUP_DELAY_TIMER_CYCLES(8), .OST_CYCLES(8), .WDT_TICKS(8))
   i_reset_clock_supervisor (.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bootCfg(bootCfg), .porEvent(porEvent),
      .brownoutDet(brownoutDet), .extResetN(extResetN), .wdtOscTick(wdtOscTick),
      .primActivity(primActivity), .wakeIrq(wakeIrq), .coreResetN(coreResetN),
      .clkCtrl(clkCtrl), .borTripSel(borTripSel), .irq(irq));
   core_model i_core_model (.sys_clk(sys_clk), .clkCtrl(clkCtrl), .primOn(primOn),
      .tickOn(tickOn), .primActivity(primActivity), .wdtOscTick(wdtOscTick));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      // Only the bench watchdog ends a wait for the answer.
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   function automatic logic [31:0] fld(input logic [31:0] v, input int lsb, input int w);
      return (v >> lsb) & ((32'h1 << w) - 1);
   endfunction
   // A bounded wait for the core reset level; returns the cycles spent.
   task automatic waitCore(input logic lvl, input int lim);
      n = 0;
      while (coreResetN !== lvl && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      check("core level", coreResetN, lvl);
   endtask
   initial begin
      #200us;
      miscompares++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hf27f_fea9));
      repeat (4) @(posedge sys_clk);
      check("core held", coreResetN, 0);
      nrst <= 1;
      @(posedge sys_clk);
      waitCore(1, 40);
      // Both delays run together, so the hold is about eight cycles, not sixteen.
      check("hold span", n >= 8 && n <= 12, 1);
      check("boot src", clkCtrl.src, SRC_PRIMARY);
      check("bor trip", borTripSel, bootCfg.borLevel);
      apb(0, CLK_CTRL_OFS, 0);
      check("cur src", fld(rd, CC_CURSRC_LSB, 2), SRC_PRIMARY);
      apb(0, 8'h20, 0);
      check("unmapped err", err, 1);
      check("unmapped data", rd, 0);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         apb(1, IRQ_MASK_OFS, v);
         apb(0, IRQ_MASK_OFS, 0);
         check("mask rw", rd, fld(v, 0, IRQ_W));
      end
      apb(1, IRQ_MASK_OFS, 32'h0000_000F);
      apb(1, CLK_CTRL_OFS, (32'h1 << CC_SWITCH_BIT) | SRC_FRC);
      repeat (4) @(posedge sys_clk);
      check("switch src", clkCtrl.src, SRC_FRC);
      check("switch irq", irq, 1);
      apb(1, IRQ_STAT_OFS, 32'h0000_000F);
      @(posedge sys_clk);
      check("irq cleared", irq, 0);
      // Divide by four and multiplier code 1 come along with the switch back.
      apb(1, CLK_CTRL_OFS, 32'h0000_0156 | SRC_PRIMARY);
      n = 0;
      repeat (8) begin
         @(posedge sys_clk);
         n += clkCtrl.sysTick;
      end
      check("tick rate", n, 2);
      check("pll sel", clkCtrl.pllMul, 1);
      repeat (20) @(posedge sys_clk);
      check("back to xtal", clkCtrl.src, SRC_PRIMARY);
      primOn <= 0;
      repeat (CFM_LIMIT + 20) @(posedge sys_clk);
      apb(0, CLK_CTRL_OFS, 0);
      check("fail flag", rd[CC_FAIL_BIT], 1);
      check("fail safe src", clkCtrl.src, SRC_FRC);
      apb(0, IRQ_STAT_OFS, 0);
      check("fail stat", rd[IRQ_CFAIL], 1);
      apb(1, IRQ_STAT_OFS, 32'h0000_000F);
      primOn <= 1;
      apb(1, PWR_CTRL_OFS, 32'h1 << PC_SLEEP_BIT);
      repeat (2) @(posedge sys_clk);
      check("sleep osc off", clkCtrl.oscEn, 0);
      wakeIrq <= 1;
      repeat (3) @(posedge sys_clk);
      wakeIrq <= 0;
      check("wake osc", clkCtrl.oscEn, 1);
      check("wake core clk", clkCtrl.coreClkEn, 1);
      apb(1, PWR_CTRL_OFS, 32'h1 << PC_IDLE_BIT);
      repeat (2) @(posedge sys_clk);
      check("idle osc on", clkCtrl.oscEn, 1);
      check("idle core off", clkCtrl.coreClkEn, 0);
      check("idle periph on", clkCtrl.periphClkEn, 1);
      wakeIrq <= 1;
      repeat (3) @(posedge sys_clk);
      wakeIrq <= 0;
      check("idle wake", clkCtrl.coreClkEn, 1);
      apb(1, PWR_CTRL_OFS, 32'h1 << PC_WDT_EN_BIT);
      repeat (50) @(posedge sys_clk);
      check("no ticks no bite", coreResetN, 1);
      tickOn <= 1;
      waitCore(0, 200);
      tickOn <= 0;
      check("soft wdt bite", coreResetN, 0);
      waitCore(1, 100);
      apb(0, RST_CAUSE_OFS, 0);
      check("wdt cause", rd[CAUSE_WDT], 1);
      apb(1, RST_CAUSE_OFS, 32'h0000_000F);
      extResetN <= 0;
      repeat (2) @(posedge sys_clk);
      extResetN <= 1;
      check("ext reset", coreResetN, 0);
      waitCore(1, 100);
      apb(0, RST_CAUSE_OFS, 0);
      check("ext cause", rd[CAUSE_EXT], 1);
      porEvent <= 1;
      @(posedge sys_clk);
      porEvent <= 0;
      repeat (2) @(posedge sys_clk);
      check("por reset", coreResetN, 0);
      waitCore(1, 100);
      apb(0, RST_CAUSE_OFS, 0);
      check("por cause", rd[CAUSE_POR], 1);
      check("por boot src", clkCtrl.src, SRC_PRIMARY);
      // A brown-out is no power-up: only the start-up delay holds the core.
      brownoutDet <= 1;
      repeat (2) @(posedge sys_clk);
      brownoutDet <= 0;
      check("bor reset", coreResetN, 0);
      waitCore(1, 100);
      check("bor hold", n >= 8, 1);
      apb(0, RST_CAUSE_OFS, 0);
      check("bor cause", rd[CAUSE_BOR], 1);
      finish_test();
   end
endmodule
